// ---- hw/audio_front_pkg.sv ----
// Constants, types and field layouts of the control port and audio receiver
package audio_front_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam logic [6:0] BASE_ID = 7'h6c;
  localparam logic [7:0] REG_FORMAT = 8'h02;
  localparam logic [7:0] REG_SLOT = 8'h03;
  localparam logic [7:0] FORMAT_RST = 8'h04;
  localparam logic [7:0] SLOT_RST = 8'h00;
  localparam int SRC_BIT = 6;
  localparam logic [2:0] FMT_I2S = 3'h4;
  localparam logic [2:0] FMT_LJ = 3'h5;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [5:0] WORD_W = 6'h20;
  localparam logic [5:0] TDM_SLOT_BITS = 6'h20;
  localparam logic [8:0] STEREO_MAX_BCLK = 9'h040;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_BCLK = 2;
  localparam int SY_LR = 3;
  localparam int SY_DIN = 4;
  localparam int SY_STRAP = 5;
  localparam int SYNC_W = 8;
  typedef enum logic [2:0] {I2C_IDLE, I2C_DEV, I2C_REG, I2C_WDATA, I2C_ACK, I2C_RDATA,
    I2C_RACK} i2c_state_t;

  function automatic logic [5:0] rj_prec(input logic [1:0] code);
    case (code)
      2'h0: rj_prec = 6'h18;
      2'h1: rj_prec = 6'h14;
      2'h2: rj_prec = 6'h12;
      default: rj_prec = 6'h10;
    endcase
  endfunction : rj_prec
endpackage : audio_front_pkg

// ---- hw/tdm_audio_input.sv ----
// Control port slave, slot-selecting audio receiver and sample FIFO
`timescale 1ns/10ps

module sample_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_in_valid, // Word offered
  input wire logic [W-1:0] i_in_data, // Word in
  output logic o_in_ready, // Room for a word
  output logic o_out_valid, // Word available
  output logic [W-1:0] o_out_data, // Oldest word
  input wire logic i_out_ready // Sink takes word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic push;
  logic pop;

  assign o_in_ready = st_ff.cnt != (AW+1)'(DEPTH);
  assign o_out_valid = st_ff.cnt != '0;
  assign o_out_data = st_ff.mem[st_ff.rp];

  always_comb begin
    nxt_st = st_ff;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    if (push) begin
      nxt_st.mem[st_ff.wp] = i_in_data;
      nxt_st.wp = (st_ff.wp == AW'(DEPTH-1)) ? '0 : st_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_st.rp = (st_ff.rp == AW'(DEPTH-1)) ? '0 : st_ff.rp + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : sample_fifo

module tdm_audio_input import audio_front_pkg::*; #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic i_clk, // Core clock, 20 MHz
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_scl, // Control bus clock pin
  input wire logic i_sda, // Control bus data pin level
  output logic o_sda_out, // Data pin drive value, always low
  output logic o_sda_oe, // Data pin pulled low when high
  input wire logic [1:0] i_strap_low_select, // Low strap level, 0 gnd to 3 supply
  input wire logic i_strap_high_select, // High strap, 1 for pull-down
  input wire logic i_bclk, // Bit clock
  input wire logic i_lrclk, // Frame clock
  input wire logic i_serial_audio_in, // Serial audio data
  output logic o_sample_valid, // Sample word available
  output logic [31:0] o_sample_data, // Sample word, MSB aligned
  input wire logic i_sample_ready, // Sink takes sample
  output logic [2:0] o_play_slot, // Slot in use for playback
  output logic [2:0] o_framing_format_field // Current format code
);
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic scl_q;
    logic sda_q;
    logic bclk_q;
    logic strap_done;
    logic [1:0] strap_cnt;
    logic [2:0] strap_ofs;
    i2c_state_t i2c;
    i2c_state_t ack_to;
    logic [3:0] bcnt;
    logic [7:0] shr;
    logic [7:0] ptr;
    logic nack;
    logic sda_oe;
    logic sda_out;
    logic [7:0] fmt;
    logic [7:0] slot_reg;
    logic lr_q;
    logic [31:0] ash;
    logic [8:0] fcnt;
    logic [8:0] flen;
    logic [5:0] bis;
    logic [2:0] sidx;
    logic [31:0] word;
    logic word_vld;
    logic out_vld;
    logic [31:0] out_data;
    logic [2:0] play_slot;
  } top_st_t;
  top_st_t st_ff;
  top_st_t nxt_st;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [6:0] bus_identifier;
  logic [7:0] rd_byte;
  logic load;
  logic fstart;
  logic i2s;
  logic [5:0] slot_w;
  logic [5:0] nbis;
  logic [5:0] prec;
  logic [31:0] nash;
  logic [2:0] sel;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic fifo_out_ready;

  sample_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(st_ff.word_vld),
    .i_in_data(st_ff.word),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_out_ready)
  );

  assign fifo_out_ready = !st_ff.out_vld || i_sample_ready;

  always_comb begin
    nxt_st = st_ff;
    load = 1'b0;
    nxt_st.sync1 = {i_strap_high_select, i_strap_low_select, i_serial_audio_in, i_lrclk,
      i_bclk, i_sda, i_scl};
    nxt_st.sync2 = st_ff.sync1;
    scl = st_ff.sync2[SY_SCL];
    sda = st_ff.sync2[SY_SDA];
    nxt_st.scl_q = scl;
    nxt_st.sda_q = sda;
    nxt_st.bclk_q = st_ff.sync2[SY_BCLK];
    // Edges are judged on the 20 MHz clock, ample for a 400 kHz bus clock
    scl_rise = scl && !st_ff.scl_q;
    scl_fall = !scl && st_ff.scl_q;
    start_cond = scl && st_ff.scl_q && st_ff.sda_q && !sda;
    stop_cond = scl && st_ff.scl_q && !st_ff.sda_q && sda;

    // Straps are caught once, a few cycles after reset release
    if (!st_ff.strap_done) begin
      nxt_st.strap_cnt = st_ff.strap_cnt + 1'b1;
      if (st_ff.strap_cnt == STRAP_SETTLE) begin
        nxt_st.strap_done = 1'b1;
        nxt_st.strap_ofs = st_ff.sync2[SY_STRAP +: 3];
      end
    end
    bus_identifier = BASE_ID + {4'h0, st_ff.strap_ofs};

    rd_byte = 8'h00;
    if (st_ff.ptr == REG_FORMAT) begin
      rd_byte = st_ff.fmt;
    end else if (st_ff.ptr == REG_SLOT) begin
      rd_byte = st_ff.slot_reg;
    end

    // Only the data line is ever driven; the bus clock is never held
    if (stop_cond) begin
      nxt_st.i2c = I2C_IDLE;
      nxt_st.sda_oe = 1'b0;
    end else if (start_cond) begin
      nxt_st.i2c = I2C_DEV;
      nxt_st.bcnt = '0;
      nxt_st.sda_oe = 1'b0;
    end else begin
      case (st_ff.i2c)
        I2C_DEV, I2C_REG, I2C_WDATA: begin
          if (scl_rise) begin
            nxt_st.shr = {st_ff.shr[6:0], sda};
            nxt_st.bcnt = st_ff.bcnt + 1'b1;
          end else if (scl_fall && st_ff.bcnt == BYTE_BITS) begin
            nxt_st.bcnt = '0;
            nxt_st.i2c = I2C_ACK;
            nxt_st.sda_oe = 1'b1;
            case (st_ff.i2c)
              I2C_DEV: begin
                if (st_ff.shr[7:1] != bus_identifier) begin
                  nxt_st.i2c = I2C_IDLE;
                  nxt_st.sda_oe = 1'b0;
                end
                nxt_st.ack_to = st_ff.shr[0] ? I2C_RDATA : I2C_REG;
              end
              I2C_REG: begin
                nxt_st.ptr = st_ff.shr;
                nxt_st.ack_to = I2C_WDATA;
              end
              default: begin
                if (st_ff.ptr == REG_FORMAT) begin
                  nxt_st.fmt = st_ff.shr;
                end else if (st_ff.ptr == REG_SLOT) begin
                  nxt_st.slot_reg = st_ff.shr;
                end
                nxt_st.ptr = st_ff.ptr + 1'b1;
                nxt_st.ack_to = I2C_WDATA;
              end
            endcase
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.i2c = st_ff.ack_to;
            load = st_ff.ack_to == I2C_RDATA;
          end
        end
        I2C_RDATA: begin
          if (scl_fall) begin
            if (st_ff.bcnt == BYTE_BITS) begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.i2c = I2C_RACK;
            end else begin
              nxt_st.shr = {st_ff.shr[6:0], 1'b0};
              nxt_st.sda_oe = !st_ff.shr[6];
              nxt_st.bcnt = st_ff.bcnt + 1'b1;
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise) begin
            nxt_st.nack = sda;
          end else if (scl_fall) begin
            if (st_ff.nack) begin
              nxt_st.i2c = I2C_IDLE;
            end else begin
              nxt_st.i2c = I2C_RDATA;
              load = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (load) begin
      nxt_st.shr = rd_byte;
      nxt_st.sda_oe = !rd_byte[7];
      nxt_st.bcnt = 4'h1;
      nxt_st.ptr = st_ff.ptr + 1'b1;
    end

    // Audio receiver; a pending word waits for FIFO room, a new one replaces it
    if (st_ff.word_vld && fifo_in_ready) begin
      nxt_st.word_vld = 1'b0;
    end
    i2s = st_ff.fmt[2:0] == FMT_I2S;
    fstart = st_ff.sync2[SY_LR] && !st_ff.lr_q;
    slot_w = (st_ff.flen > STEREO_MAX_BCLK) ? TDM_SLOT_BITS : st_ff.flen[6:1];
    prec = st_ff.fmt[2] ? slot_w : rj_prec(st_ff.fmt[1:0]);
    nash = {st_ff.ash[30:0], st_ff.sync2[SY_DIN]};
    nbis = st_ff.bis + 1'b1;
    sel = st_ff.fmt[SRC_BIT] ? st_ff.slot_reg[2:0] : st_ff.strap_ofs;
    if (st_ff.sync2[SY_BCLK] && !st_ff.bclk_q) begin
      nxt_st.lr_q = st_ff.sync2[SY_LR];
      nxt_st.ash = nash;
      nxt_st.fcnt = fstart ? '0 : st_ff.fcnt + 1'b1;
      if (fstart) begin
        nxt_st.flen = st_ff.fcnt + 1'b1;
      end
      // Left-justified words begin on the edge that shows the frame start
      if (fstart && !i2s) begin
        nbis = 6'h1;
      end
      // I2S slots lag by one bit, so the frame start edge ends the last slot
      if (nbis == slot_w && slot_w != '0) begin
        if (st_ff.sidx == sel) begin
          nxt_st.word = nash << (WORD_W - prec);
          nxt_st.word_vld = 1'b1;
        end
        nbis = '0;
        nxt_st.sidx = st_ff.sidx + 1'b1;
      end
      if (fstart) begin
        nxt_st.sidx = '0;
        if (i2s) begin
          nbis = '0;
        end
      end
      nxt_st.bis = nbis;
    end

    if (fifo_out_ready) begin
      nxt_st.out_vld = fifo_out_valid;
      if (fifo_out_valid) begin
        nxt_st.out_data = fifo_out_data;
      end
    end
    nxt_st.play_slot = sel;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
      st_ff.fmt <= FORMAT_RST;
      st_ff.slot_reg <= SLOT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sda_out = st_ff.sda_out;
  assign o_sda_oe = st_ff.sda_oe;
  assign o_sample_valid = st_ff.out_vld;
  assign o_sample_data = st_ff.out_data;
  assign o_play_slot = st_ff.play_slot;
  assign o_framing_format_field = st_ff.fmt[2:0];
endmodule : tdm_audio_input

// ---- test/audio_host_model.sv ----
// Host-side audio source: bit clock, frame clock and serial data
`timescale 1ns/10ps
module audio_host_model (
  output logic o_bclk, // Bit clock
  output logic o_lrclk, // Frame clock
  output logic o_serial_audio_in // Serial data
);
  initial begin
    o_bclk = 1'b0;
    o_lrclk = 1'b0;
    o_serial_audio_in = 1'b0;
  end
  function automatic logic [31:0] slot_word(input int k);
    return {8'ha0 + 8'(k), 24'h3c5a96};
  endfunction : slot_word
  // Frames plus one closing bit; bclk stands still after
  task automatic play(input int f, input int len, input logic i2s);
    int b;
    int p;
    int ss;
    logic [31:0] w;
    ss = (len > 64) ? 32 : len / 2;
    #7;
    for (int n = 0; n <= f * len; n++) begin
      b = n % len;
      p = i2s ? (b + len - 1) % len : b;
      o_lrclk = (len > 64) ? (b == 0) : (b < len / 2);
      w = slot_word(p / ss);
      o_serial_audio_in = w[31 - p % ss];
      #200 o_bclk = 1'b1;
      #200 o_bclk = 1'b0;
    end
    o_serial_audio_in = ~o_serial_audio_in;
  endtask : play
endmodule : audio_host_model

// ---- test/front_monitor.sv ----
// Port checker for the audio front end, bound to its top module
`timescale 1ns/10ps
module front_monitor import audio_front_pkg::*; (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_scl, // Bus clock
  input wire logic o_sda_out, // Drive value
  input wire logic o_sda_oe, // Pull enable
  input wire logic [1:0] i_strap_low_select, // Strap
  input wire logic i_strap_high_select, // Strap
  input wire logic o_sample_valid, // Valid
  input wire logic [31:0] o_sample_data, // Word
  input wire logic i_sample_ready, // Ready
  input wire logic [2:0] o_play_slot, // Slot
  input wire logic [2:0] o_framing_format_field // Format
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  drive_low_a: assert property (o_sda_out == 1'b0)
    else $error("data pin driven high");
  ack_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data changed with clock high");
  ack_hold_a: assert property ($rose(o_sda_oe) |=> o_sda_oe [*4])
    else $error("drive released early");
  fmt_reset_a: assert property ($rose(i_rst_n) |-> o_framing_format_field == FMT_I2S)
    else $error("format reset value wrong");
  slot_strap_a: assert property ($rose(i_rst_n) |-> ##[1:10]
    o_play_slot == {i_strap_high_select, i_strap_low_select}) else $error("strap slot wrong");
  fmt_edge_a: assert property ($changed(o_framing_format_field) |-> !i_scl)
    else $error("format changed mid bit");
  word_hold_a: assert property (o_sample_valid && !i_sample_ready |=>
    o_sample_valid && $stable(o_sample_data)) else $error("word not held");
  rj_align_a: assert property (o_sample_valid && !o_framing_format_field[2] |->
    o_sample_data[7:0] == 8'h00) else $error("low bits set");
  cover property ($rose(o_sda_oe));
  cover property (o_sample_valid && i_sample_ready);
  cover property ($changed(o_play_slot));
endmodule : front_monitor

bind tdm_audio_input front_monitor i_mon (.i_clk, .i_rst_n, .i_scl, .o_sda_out, .o_sda_oe,
  .i_strap_low_select, .i_strap_high_select, .o_sample_valid, .o_sample_data,
  .i_sample_ready, .o_play_slot, .o_framing_format_field);

// ---- test/test_tdm_audio_input.sv ----
// Bench for the audio front end: bus register access and audio frames
`timescale 1ns/10ps
module test_tdm_audio_input import audio_front_pkg::*; ;
  localparam logic [6:0] DEV_ID = BASE_ID + 7'h06;
  logic clk, rst_n, scl, sda_m, ready, oe, vld, bclk, lrclk, serial_audio_in, ok;
  logic [31:0] dat, w;
  logic [2:0] slot, fmt;
  logic [1:0] strap_lo;
  logic strap_hi;
  logic [15:0] v;
  logic [31:0] q[$];
  int err_total, cmp_count;
  wire sda = sda_m & ~oe;
  tdm_audio_input #(.FIFO_DEPTH(4)) i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl),
    .i_sda(sda), .o_sda_out(), .o_sda_oe(oe), .i_strap_low_select(strap_lo),
    .i_strap_high_select(strap_hi), .i_bclk(bclk), .i_lrclk(lrclk), .i_serial_audio_in(serial_audio_in),
    .o_sample_valid(vld), .o_sample_data(dat), .i_sample_ready(ready), .o_play_slot(slot),
    .o_framing_format_field(fmt));
  audio_host_model i_host (.o_bclk(bclk), .o_lrclk(lrclk), .o_serial_audio_in(serial_audio_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (vld === 1'b1 && ready === 1'b1) q.push_back(dat);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task automatic hb;
    repeat (17) @(negedge clk);
  endtask : hb
  task automatic bit_x(input logic b, output logic r);
    sda_m = b;
    hb;
    scl = 1'b1;
    hb;
    r = sda;
    scl = 1'b0;
    hb;
  endtask : bit_x
  task automatic start_c;
    sda_m = 1'b1;
    hb;
    scl = 1'b1;
    hb;
    sda_m = 1'b0;
    hb;
    scl = 1'b0;
  endtask : start_c
  task automatic stop_c;
    sda_m = 1'b0;
    hb;
    scl = 1'b1;
    hb;
    sda_m = 1'b1;
    hb;
  endtask : stop_c
  task automatic tx(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ok = ok & ~r;
  endtask : tx
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask : rx
  task automatic wr(input logic [6:0] id, input logic [15:0] d);
    ok = 1'b1;
    start_c;
    tx({id, 1'b0});
    tx(REG_FORMAT);
    tx(d[15:8]);
    tx(d[7:0]);
    stop_c;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ok = 1'b1;
    start_c;
    tx({DEV_ID, 1'b0});
    tx(a);
    start_c;
    tx({DEV_ID, 1'b1});
    rx(1'b0, v[15:8]);
    rx(1'b1, v[7:0]);
    stop_c;
  endtask : rd
  task automatic aud(input logic [15:0] regs, input int len, input logic i2s,
                     input logic [31:0] exp);
    wr(DEV_ID, regs);
    chk(ok, 1'b1);
    q.delete();
    i_host.play(5, len, i2s);
    repeat (20) @(negedge clk);
    chk(q.size() >= 2, 1'b1);
    chk(q[$], exp);
    chk(q[$ - 1], exp);
  endtask : aud
  initial begin
    rst_n = 1'b0;
    strap_lo = 2'h2;
    strap_hi = 1'b1;
    scl = 1'b1;
    sda_m = 1'b1;
    ready = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (20) @(negedge clk);
    chk(fmt, FMT_I2S);
    chk(slot, 3'(DEV_ID - BASE_ID));
    rd(REG_FORMAT);
    chk({ok, v}, {1'b1, FORMAT_RST, SLOT_RST});
    rd(8'h40);
    chk({ok, v}, 17'h10000);
    wr(BASE_ID, 16'h0000);
    chk({ok, fmt}, {1'b0, FMT_I2S});
    aud(16'h4503, 128, 1'b0, i_host.slot_word(3));
    chk(slot, 3'h3);
    rd(REG_FORMAT);
    chk({ok, v}, 17'h14503);
    aud(16'h4401, 64, 1'b1, i_host.slot_word(1));
    w = i_host.slot_word(0);
    aud(16'h4300, 48, 1'b0, {w[23:8], 16'h0000});
    wr(DEV_ID, 16'h0500);
    chk(slot, 3'(DEV_ID - BASE_ID));
    q.delete();
    ready = 1'b0;
    i_host.play(6, 256, 1'b0);
    @(negedge clk);
    chk(vld, 1'b1);
    ready = 1'b1;
    for (int t = 0; t < 200 && vld !== 1'b0; t++) @(negedge clk);
    chk(q.size() >= 4, 1'b1);
    chk(q[$], i_host.slot_word(6));
    chk(vld, 1'b0);
    finish_test;
  end
endmodule : test_tdm_audio_input
